// ### hw/dmr_map.svh
`ifndef DMR_MAP_SVH
`define DMR_MAP_SVH
`define DMR_ADR_OVERRIDE 16'h0001
`define DMR_ADR_COMMAND 16'h0002
`define DMR_ADR_ACT_KIND 16'h0003
`define DMR_ADR_REL_POS 16'h0004
`define DMR_ADR_COLL_FAULT 16'h0008
`define DMR_ADR_SERIAL1 16'h0064
`define DMR_ADR_SERIAL2 16'h0065
`define DMR_ADR_SERIAL4 16'h0066
`define DMR_ADR_FW_VER 16'h0067
`define DMR_ADR_MALF 16'h0068
`define DMR_ADR_BUS_FAIL 16'h006C
`define DMR_RST_OVERRIDE 16'h0000
`define DMR_RST_BUS_FAIL 16'h0001
`define DMR_ACT_KIND_VAL 16'h0003
`define DMR_POS_CLOSED 16'h0000
`define DMR_POS_MID 16'h1388
`define DMR_POS_OPEN 16'h2710
`define DMR_OVR_OPEN 16'h0001
`define DMR_OVR_CLOSE 16'h0002
`define DMR_CMD_TEST 16'h0002
`define DMR_CMD_RESET 16'h0004
`define DMR_BIT_PATH 1
`define DMR_BIT_OVERLOAD 2
`define DMR_BIT_SAFETY 4
`define DMR_BIT_DUCT_TEMP 6
`define DMR_BIT_SMOKE 7
`define DMR_BIT_INTERNAL 8
`define DMR_BIT_BUS_MON 10
`define DMR_BIT_LOCAL_OVR 11
`define DMR_STICKY_MASK 16'h0011
`define DMR_CLK_HZ 125000000
`define DMR_TRAVEL_S 150
`define DMR_BUS_MON_S 120
`define DMR_BUTTON_MS 1000
`define DMR_FLASH_MS 250
`define DMR_ACT_PULSE_MS 50
`endif

// ### hw/dmr_pkg.sv
package dmr_pkg;
	typedef enum logic [2:0] {
		DMR_FC_RD_DISC = 3'h0,
		DMR_FC_RD_HOLD = 3'h1,
		DMR_FC_RD_INP = 3'h2,
		DMR_FC_WR_ONE = 3'h3,
		DMR_FC_WR_MULTI = 3'h4
	} dmr_func_t;
	typedef enum logic [2:0] {
		DMR_MV_IDLE = 3'b001,
		DMR_MV_OPENING = 3'b010,
		DMR_MV_CLOSING = 3'b100
	} dmr_move_t;
endpackage

// ### hw/dmr_register_map.sv
`include "dmr_map.svh"
`timescale 1ns/1ns
`default_nettype none
module dmr_register_map #(
	parameter int CLK_HZ = `DMR_CLK_HZ,
	parameter int TRAVEL_S = `DMR_TRAVEL_S,
	parameter int BUS_MON_S = `DMR_BUS_MON_S,
	parameter int BUTTON_MS = `DMR_BUTTON_MS,
	parameter int FLASH_MS = `DMR_FLASH_MS,
	parameter int ACT_PULSE_MS = `DMR_ACT_PULSE_MS,
	parameter logic [15:0] SERIAL1 = 16'h0001,
	parameter logic [15:0] SERIAL2 = 16'h0002,
	parameter logic [15:0] SERIAL4 = 16'h0004,
	parameter logic [15:0] FW_VERSION = 16'h0064,
	parameter logic [15:0] BUS_FAIL_STORED = `DMR_RST_BUS_FAIL
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire dmr_pkg::dmr_func_t req_func,
	input wire logic [15:0] req_addr,
	input wire logic [15:0] req_wdata,
	output logic [15:0] rsp_rdata,
	output logic rsp_valid,
	output logic rsp_error,
	output logic [15:0] nv_bus_fail,
	output logic nv_write,
	input wire logic bus_rx_active,
	input wire logic bus_tx_active,
	input wire logic sw_open_limit,
	input wire logic sw_closed_limit,
	input wire logic sw_mid_position,
	input wire logic motor_drive_open,
	input wire logic thermal_trip_device,
	input wire logic smoke_alarm,
	input wire logic internal_fault,
	input wire logic path_increased,
	input wire logic mech_overload,
	input wire logic local_override,
	input wire logic test_button,
	output logic damper_open_cmd,
	output logic test_run_start,
	output logic led_green,
	output logic led_yellow,
	output logic led_red,
	output logic led_bus
);
	// Second-long counts overflow 32 bits at the full clock rate
	localparam longint TRAVEL_CYC = longint'(CLK_HZ) * TRAVEL_S;
	localparam longint BUS_MON_CYC = longint'(CLK_HZ) * BUS_MON_S;
	localparam int BUTTON_CYC = int'((longint'(CLK_HZ) * BUTTON_MS) / 1000);
	localparam int FLASH_CYC = int'((longint'(CLK_HZ) * FLASH_MS) / 1000);
	localparam int ACT_CYC = int'((longint'(CLK_HZ) * ACT_PULSE_MS) / 1000);

	logic [15:0] override_r;
	logic [15:0] bus_fail_r;
	logic [15:0] malf_r;
	logic [15:0] malf_nxt;
	logic [39:0] travel_cnt_r;
	logic [39:0] mon_cnt_r;
	logic [31:0] btn_cnt_r;
	logic [31:0] flash_cnt_r;
	logic [31:0] act_cnt_r;
	logic flash_r;
	logic btn_done_r;
	logic travel_fail_r;
	logic mon_trip_r;
	dmr_pkg::dmr_move_t move_r;
	dmr_pkg::dmr_move_t move_nxt;

	// Word address from bit address: a discrete read returns one bit
	wire is_disc = req_func == dmr_pkg::DMR_FC_RD_DISC;
	wire [15:0] word_addr = is_disc ? {4'h0, req_addr[15:4]} : req_addr;
	wire is_write = req_func == dmr_pkg::DMR_FC_WR_ONE ||
		req_func == dmr_pkg::DMR_FC_WR_MULTI;
	wire wr = req_valid && is_write;
	wire wr_ovr = wr && req_addr == `DMR_ADR_OVERRIDE;
	wire wr_cmd = wr && req_addr == `DMR_ADR_COMMAND;
	wire wr_bfp = wr && req_addr == `DMR_ADR_BUS_FAIL;
	wire ovr_ok = req_wdata == `DMR_OVR_OPEN ||
		req_wdata == `DMR_OVR_CLOSE;
	wire bfp_ok = req_wdata == 16'h0000 || req_wdata == 16'h0001;
	wire btn_fire = test_button && btn_cnt_r == BUTTON_CYC - 1;
	wire cmd_test = wr_cmd && req_wdata == `DMR_CMD_TEST;
	wire cmd_reset = wr_cmd && req_wdata == `DMR_CMD_RESET;
	wire clear_faults = cmd_reset || btn_fire;
	wire mon_on = bus_fail_r != 16'h0000;
	wire ext_fault = thermal_trip_device || smoke_alarm;
	wire want_open = override_r == `DMR_OVR_OPEN && !ext_fault &&
		!mon_trip_r;
	wire coll = |malf_r[7:0];

	wire [15:0] rel_pos = sw_open_limit ? `DMR_POS_OPEN :
		sw_mid_position ? `DMR_POS_MID : `DMR_POS_CLOSED;

	// Flat table: every read function sees the same words
	logic [15:0] word;
	always_comb begin
		case (word_addr)
		`DMR_ADR_OVERRIDE: word = override_r;
		`DMR_ADR_COMMAND: word = 16'h0000;
		`DMR_ADR_ACT_KIND: word = `DMR_ACT_KIND_VAL;
		`DMR_ADR_REL_POS: word = rel_pos;
		`DMR_ADR_COLL_FAULT: word = {15'h0000, coll};
		`DMR_ADR_SERIAL1: word = SERIAL1;
		`DMR_ADR_SERIAL2: word = SERIAL2;
		`DMR_ADR_SERIAL4: word = SERIAL4;
		`DMR_ADR_FW_VER: word = FW_VERSION;
		`DMR_ADR_MALF: word = malf_r;
		`DMR_ADR_BUS_FAIL: word = bus_fail_r;
		default: word = 16'h0000;
		endcase
	end
	wire [15:0] rd_val = is_disc ? {15'h0000, word[req_addr[3:0]]} : word;
	wire func_ok = req_func == dmr_pkg::DMR_FC_RD_DISC ||
		req_func == dmr_pkg::DMR_FC_RD_HOLD ||
		req_func == dmr_pkg::DMR_FC_RD_INP || is_write;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rsp_valid <= 1'b0;
			rsp_error <= 1'b0;
			rsp_rdata <= 16'h0000;
		end else begin
			rsp_valid <= req_valid;
			rsp_error <= req_valid && !func_ok;
			rsp_rdata <= (req_valid && !is_write) ? rd_val : 16'h0000;
		end
	end

	// Override is volatile; a rejected value leaves it alone
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			override_r <= `DMR_RST_OVERRIDE;
		else if (wr_ovr && ovr_ok)
			override_r <= req_wdata;
	end

	// Bus fail position resets to the fixed DMR_RST_BUS_FAIL value, not the retained store
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			bus_fail_r <= `DMR_RST_BUS_FAIL;
		else if (wr_bfp && bfp_ok)
			bus_fail_r <= req_wdata;
	end
	logic loaded_r;
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			loaded_r <= 1'b0;
		else
			loaded_r <= 1'b1;
	end
	assign nv_bus_fail = bus_fail_r;
	assign nv_write = wr_bfp && bfp_ok;

	// Bus watchdog: any override write, even rejected, is a refresh
	always_ff @(posedge core_clk) begin
		if (sys_rst || wr_ovr || !mon_on) begin
			mon_cnt_r <= 40'h00_0000_0000;
			mon_trip_r <= 1'b0;
		end else if (mon_cnt_r == 40'(BUS_MON_CYC - 1)) begin
			mon_trip_r <= 1'b1;
		end else begin
			mon_cnt_r <= mon_cnt_r + 40'h00_0000_0001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst || !test_button) begin
			btn_cnt_r <= 32'h0000_0000;
			btn_done_r <= 1'b0;
		end else if (!btn_done_r) begin
			btn_cnt_r <= btn_cnt_r + 32'h0000_0001;
			btn_done_r <= btn_fire;
		end
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			test_run_start <= 1'b0;
		else
			test_run_start <= cmd_test || btn_fire;
	end

	// Malfunction word: hardware set wins over a reset command
	always_comb begin
		malf_nxt = clear_faults ? (malf_r & `DMR_STICKY_MASK) : malf_r;
		malf_nxt[`DMR_BIT_PATH] = malf_nxt[`DMR_BIT_PATH] | path_increased;
		malf_nxt[`DMR_BIT_OVERLOAD] = malf_nxt[`DMR_BIT_OVERLOAD] |
			mech_overload;
		malf_nxt[`DMR_BIT_SAFETY] = malf_nxt[`DMR_BIT_SAFETY] |
			internal_fault | travel_fail_r;
		malf_nxt[`DMR_BIT_DUCT_TEMP] = malf_nxt[`DMR_BIT_DUCT_TEMP] |
			thermal_trip_device;
		malf_nxt[`DMR_BIT_SMOKE] = malf_nxt[`DMR_BIT_SMOKE] | smoke_alarm;
		malf_nxt[`DMR_BIT_INTERNAL] = move_r != dmr_pkg::DMR_MV_IDLE;
		malf_nxt[`DMR_BIT_BUS_MON] = malf_nxt[`DMR_BIT_BUS_MON] |
			mon_trip_r;
		malf_nxt[`DMR_BIT_LOCAL_OVR] = local_override;
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			malf_r <= 16'h0000;
		else
			malf_r <= malf_nxt;
	end

	// Travel supervision
	always_comb begin
		move_nxt = move_r;
		case (move_r)
		dmr_pkg::DMR_MV_IDLE: begin
			if (damper_open_cmd && !sw_open_limit)
				move_nxt = dmr_pkg::DMR_MV_OPENING;
			else if (!damper_open_cmd && !sw_closed_limit)
				move_nxt = dmr_pkg::DMR_MV_CLOSING;
		end
		dmr_pkg::DMR_MV_OPENING:
			if (sw_open_limit || !damper_open_cmd)
				move_nxt = dmr_pkg::DMR_MV_IDLE;
		dmr_pkg::DMR_MV_CLOSING:
			if (sw_closed_limit || damper_open_cmd)
				move_nxt = dmr_pkg::DMR_MV_IDLE;
		default: move_nxt = dmr_pkg::DMR_MV_IDLE;
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			move_r <= dmr_pkg::DMR_MV_IDLE;
			damper_open_cmd <= 1'b0;
		end else begin
			move_r <= move_nxt;
			damper_open_cmd <= want_open && loaded_r;
		end
	end
	// Timeout latches until a new travel starts from idle or a fault reset while idle
	always_ff @(posedge core_clk) begin
		if (sys_rst || move_r == dmr_pkg::DMR_MV_IDLE) begin
			travel_cnt_r <= 40'h00_0000_0000;
			if (sys_rst || clear_faults || move_nxt != move_r)
				travel_fail_r <= 1'b0;
		end else if (travel_cnt_r == 40'(TRAVEL_CYC - 1)) begin
			travel_fail_r <= 1'b1;
		end else begin
			travel_cnt_r <= travel_cnt_r + 40'h00_0000_0001;
		end
	end
	logic fail_dir_open_r;
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			fail_dir_open_r <= 1'b0;
		else if (move_r != dmr_pkg::DMR_MV_IDLE)
			fail_dir_open_r <= move_r == dmr_pkg::DMR_MV_OPENING;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst || flash_cnt_r == FLASH_CYC - 1) begin
			flash_cnt_r <= 32'h0000_0000;
			flash_r <= sys_rst ? 1'b0 : !flash_r;
		end else begin
			flash_cnt_r <= flash_cnt_r + 32'h0000_0001;
		end
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			act_cnt_r <= 32'h0000_0000;
		else if (bus_rx_active || bus_tx_active)
			act_cnt_r <= 32'(ACT_CYC);
		else if (act_cnt_r != 32'h0000_0000)
			act_cnt_r <= act_cnt_r - 32'h0000_0001;
	end

	wire opening = move_r == dmr_pkg::DMR_MV_OPENING;
	wire closing = move_r == dmr_pkg::DMR_MV_CLOSING;
	wire tf_close = travel_fail_r && !fail_dir_open_r;
	wire tf_open = travel_fail_r && fail_dir_open_r;
	wire ext_red = ext_fault || travel_fail_r;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			led_green <= 1'b0;
			led_yellow <= 1'b0;
			led_red <= 1'b0;
			led_bus <= 1'b0;
		end else begin
			led_green <= tf_open ? 1'b0 : tf_close ? flash_r :
				sw_open_limit || (opening && flash_r);
			led_yellow <= tf_close ? 1'b0 : tf_open ? flash_r :
				sw_closed_limit || (closing && flash_r);
			led_red <= internal_fault || (ext_red && flash_r);
			led_bus <= act_cnt_r != 32'h0000_0000;
		end
	end
endmodule // dmr_register_map
`default_nettype wire

// ### dv/dmr_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module dmr_master_model (
	input wire logic core_clk,
	output logic req_valid,
	output dmr_pkg::dmr_func_t req_func,
	output logic [15:0] req_addr,
	output logic [15:0] req_wdata,
	input wire logic [15:0] rsp_rdata,
	input wire logic rsp_valid,
	input wire logic rsp_error
);
	initial begin
		req_valid = 1'b0;
		req_func = dmr_pkg::DMR_FC_RD_HOLD;
		req_addr = 16'h0000;
		req_wdata = 16'h0000;
	end
	// One request, then a bounded wait for its answer
	task automatic xfer(input logic [2:0] f, input logic [15:0] a,
		input logic [15:0] d, output logic [15:0] q, output logic er,
		output logic ok);
		ok = 1'b0;
		req_valid <= 1'b1;
		req_func <= dmr_pkg::dmr_func_t'(f);
		req_addr <= a;
		req_wdata <= d;
		@(posedge core_clk);
		req_valid <= 1'b0;
		// Released lines show junk, not the last value
		req_addr <= ~a;
		req_wdata <= ~d;
		for (int i = 0; i < 4 && !ok; i++) begin
			@(posedge core_clk);
			ok = (rsp_valid === 1'b1);
		end
		q = rsp_rdata;
		er = rsp_error;
	endtask
endmodule // dmr_master_model
`default_nettype wire

// ### dv/dmr_register_map_properties.sv
`timescale 1ns/1ns
`default_nettype none
module dmr_register_map_properties (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire dmr_pkg::dmr_func_t req_func,
	input wire logic [15:0] req_addr,
	input wire logic [15:0] req_wdata,
	input wire logic [15:0] rsp_rdata,
	input wire logic rsp_valid,
	input wire logic rsp_error,
	input wire logic nv_write,
	input wire logic bus_rx_active,
	input wire logic thermal_trip_device,
	input wire logic smoke_alarm,
	input wire logic damper_open_cmd,
	input wire logic test_run_start,
	input wire logic led_bus
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	wire logic rd1 = req_valid && req_func == dmr_pkg::DMR_FC_RD_HOLD;
	wire logic wr1 = req_valid && req_func == dmr_pkg::DMR_FC_WR_ONE;
	answer_slot_a: assert property (req_valid |=> rsp_valid)
		else $error("answer missing");
	no_answer_a: assert property (!req_valid |=> !rsp_valid)
		else $error("stray answer");
	func_error_a: assert property (req_valid |=>
		rsp_error == ($past(req_func) > 3'h4)) else $error("error flag");
	kind_value_a: assert property (rd1 && req_addr == 16'h0003 |=>
		rsp_rdata == 16'h0003) else $error("kind wrong");
	reserved_zero_a: assert property (rd1 && req_addr == 16'h0000 |=>
		rsp_rdata == 16'h0000) else $error("reserved not zero");
	store_write_a: assert property (nv_write |-> req_valid &&
		req_addr == 16'h006C && req_wdata < 16'h0002) else $error("bad store");
	bus_led_a: assert property ($rose(bus_rx_active) |-> ##[1:3] led_bus)
		else $error("bus led idle");
	test_start_a: assert property (wr1 && req_addr == 16'h0002 &&
		req_wdata == 16'h0002 |-> ##[1:2] test_run_start) else $error("no start");
	start_pulse_a: assert property (test_run_start |=> !test_run_start)
		else $error("start too long");
	open_cmd_a: assert property (wr1 && req_addr == 16'h0001 &&
		req_wdata == 16'h0001 && !smoke_alarm && !thermal_trip_device
		|-> ##2 damper_open_cmd) else $error("no open");
endmodule // dmr_register_map_properties
bind dmr_register_map dmr_register_map_properties u_props (.core_clk,
	.sys_rst, .req_valid, .req_func, .req_addr, .req_wdata, .rsp_rdata,
	.rsp_valid, .rsp_error, .nv_write, .bus_rx_active, .thermal_trip_device,
	.smoke_alarm, .damper_open_cmd, .test_run_start, .led_bus);
`default_nettype wire

// ### dv/dmr_register_map_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module dmr_register_map_tb_top;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic req_valid, rsp_valid, rsp_error, nv_write;
	dmr_pkg::dmr_func_t req_func;
	logic [15:0] req_addr, req_wdata, rsp_rdata, nv_bus_fail;
	logic bus_rx_active = 1'b0, bus_tx_active = 1'b0, test_button = 1'b0;
	logic sw_open_limit = 1'b0, sw_closed_limit = 1'b1;
	logic sw_mid_position = 1'b0, internal_fault = 1'b0;
	logic thermal_trip_device = 1'b0, smoke_alarm = 1'b0;
	logic path_increased = 1'b0, mech_overload = 1'b0, local_override = 1'b0;
	logic damper_open_cmd, test_run_start;
	logic led_green, led_yellow, led_red, led_bus;
	int bad_count = 0, tests_run = 0, starts = 0;
	logic [15:0] ra[14] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4, 16'h5,
		16'h8, 16'h64, 16'h65, 16'h66, 16'h67, 16'h68, 16'h6C, 16'h69};
	logic [15:0] rv[14] = '{16'h0, 16'h0, 16'h0, 16'h3, 16'h0, 16'h0,
		16'h0, 16'h1, 16'h2, 16'h4, 16'h64, 16'h0, 16'h1, 16'h0};
	// Short second so timeouts fit the run
	dmr_register_map #(.CLK_HZ(100), .TRAVEL_S(1), .BUS_MON_S(2))
		u_dmr_register_map (.core_clk, .sys_rst, .req_valid, .req_func,
		.req_addr, .req_wdata, .rsp_rdata, .rsp_valid, .rsp_error,
		.nv_bus_fail, .nv_write, .bus_rx_active, .bus_tx_active,
		.sw_open_limit, .sw_closed_limit, .sw_mid_position,
		.motor_drive_open(1'b0), .thermal_trip_device, .smoke_alarm,
		.internal_fault, .path_increased, .mech_overload, .local_override,
		.test_button, .damper_open_cmd, .test_run_start, .led_green,
		.led_yellow, .led_red, .led_bus);
	dmr_master_model u_dmr_master_model (.core_clk, .req_valid, .req_func,
		.req_addr, .req_wdata, .rsp_rdata, .rsp_valid, .rsp_error);
	always #4 core_clk = ~core_clk;
	always @(posedge core_clk) if (test_run_start === 1'b1) starts++;
	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] s,
		input logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic acc(input logic [2:0] f, input logic [15:0] a,
		input logic [15:0] d, input logic [15:0] e);
		logic [15:0] q;
		logic er, ok;
		u_dmr_master_model.xfer(f, a, d, q, er, ok);
		chk("answer", {14'h0, er, ok}, {14'h0, f > 3'h4, 1'b1});
		if (f <= 3'h4) chk("rdata", q, e);
	endtask
	// Flashing shows as on but not steady over 80 cycles
	task automatic leds(input logic [2:0] eo, input logic [2:0] ea);
		logic [2:0] o, a;
		o = 3'h0;
		a = 3'h7;
		// Let registered LEDs follow the last input change first
		repeat (2) @(posedge core_clk);
		repeat (80) begin
			@(posedge core_clk);
			o = o | {led_red, led_green, led_yellow};
			a = a & {led_red, led_green, led_yellow};
		end
		chk("led_on", {13'h0, o}, {13'h0, eo});
		chk("led_steady", {13'h0, a}, {13'h0, ea});
	endtask
	initial begin
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		foreach (ra[i]) acc(3'(1 + i % 2), ra[i], 16'h0, rv[i]);
		acc(3'h3, 16'h006C, 16'h0, 16'h0);
		chk("nv", nv_bus_fail, 16'h0);
		acc(3'h3, 16'h006C, 16'h5, 16'h0);
		acc(3'h3, 16'h0003, 16'h9, 16'h0);
		acc(3'h1, 16'h006C, 16'h0, 16'h0);
		acc(3'h1, 16'h0003, 16'h0, 16'h3);
		leds(3'h1, 3'h1);
		internal_fault <= 1'b1;
		leds(3'h5, 3'h5);
		internal_fault <= 1'b0;
		acc(3'h3, 16'h0002, 16'h4, 16'h0);
		acc(3'h3, 16'h0001, 16'h0, 16'h0);
		acc(3'h3, 16'h0001, 16'h3, 16'h0);
		acc(3'h1, 16'h0001, 16'h0, 16'h0);
		acc(3'h4, 16'h0001, 16'h1, 16'h0);
		{sw_closed_limit, sw_mid_position} <= 2'h1;
		repeat (3) @(posedge core_clk);
		acc(3'h1, 16'h0004, 16'h0, 16'h1388);
		{sw_mid_position, sw_open_limit} <= 2'h1;
		repeat (3) @(posedge core_clk);
		acc(3'h1, 16'h0004, 16'h0, 16'h2710);
		leds(3'h2, 3'h2);
		acc(3'h3, 16'h0001, 16'h2, 16'h0);
		acc(3'h1, 16'h0001, 16'h0, 16'h2);
		sw_open_limit <= 1'b0;
		for (int d = 1; d < 3; d++) begin
			acc(3'h3, 16'h0001, 16'(d), 16'h0);
			repeat (130) @(posedge core_clk);
			leds(d == 1 ? 3'h5 : 3'h6, 3'h0);
		end
		// End the stuck travel so the activity bit drops
		sw_closed_limit <= 1'b1;
		repeat (3) @(posedge core_clk);
		acc(3'h1, 16'h0068, 16'h0, 16'h0010);
		acc(3'h2, 16'h0008, 16'h0, 16'h0001);
		{smoke_alarm, thermal_trip_device, path_increased} <= 3'h7;
		{mech_overload, local_override} <= 2'h3;
		repeat (3) @(posedge core_clk);
		acc(3'h1, 16'h0068, 16'h0, 16'h08D6);
		acc(3'h0, 16'h0686, 16'h0, 16'h0001);
		acc(3'h0, 16'h0685, 16'h0, 16'h0000);
		{smoke_alarm, thermal_trip_device, path_increased} <= 3'h0;
		{mech_overload, local_override} <= 2'h0;
		repeat (3) @(posedge core_clk);
		acc(3'h3, 16'h0002, 16'h4, 16'h0);
		acc(3'h1, 16'h0068, 16'h0, 16'h0010);
		acc(3'h3, 16'h006C, 16'h1, 16'h0);
		acc(3'h3, 16'h0001, 16'h1, 16'h0);
		repeat (230) @(posedge core_clk);
		chk("trip", {15'h0, damper_open_cmd}, 16'h0);
		acc(3'h1, 16'h0068, 16'h0, 16'h0410);
		acc(3'h3, 16'h0001, 16'h1, 16'h0);
		@(posedge core_clk);
		chk("open", {15'h0, damper_open_cmd}, 16'h1);
		acc(3'h3, 16'h0002, 16'h2, 16'h0);
		acc(3'h1, 16'h0002, 16'h0, 16'h0);
		test_button <= 1'b1;
		repeat (130) @(posedge core_clk);
		test_button <= 1'b0;
		chk("starts", 16'(starts), 16'h2);
		for (int b = 1; b < 3; b++) begin
			{bus_rx_active, bus_tx_active} <= 2'(b);
			repeat (3) @(posedge core_clk);
			chk("bus_led", {15'h0, led_bus}, 16'h1);
		end
		acc(3'h5, 16'h0001, 16'h0, 16'h0);
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		bad_count++;
		complete_run();
	end
endmodule // dmr_register_map_tb_top
`default_nettype wire
